/* design/p2c_pkg.sv */
// package: register map, field masks and pad carrier for the port 2 pad control block
package p2c_pkg;

   // ****************************************************************
   // register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [13:0] P2C_IDX_PIN_LEVELS    = 14'h000F;
   localparam logic [13:0] P2C_IDX_OUTPUT_LATCH  = 14'h0002;
   localparam logic [13:0] P2C_IDX_DIRECTION     = 14'h0F1C;
   localparam logic [13:0] P2C_IDX_PULLUP_ENABLE = 14'h0F29;
   localparam logic [13:0] P2C_IDX_DRIVE_TYPE    = 14'h0F43;

   // ****************************************************************
   // widths, field masks and reset values
   // ****************************************************************
   localparam int          P2C_WIDTH         = 8;
   localparam int          P2C_ADR_WIDTH     = 16;
   localparam int          P2C_ADR_LSB       = 2;
   localparam logic [7:0]  P2C_CTRL_MASK     = 8'hE7;
   localparam logic [7:0]  P2C_ALWAYS_PIN    = 8'h18;
   localparam logic [7:0]  P2C_RESET_BYTE    = 8'h00;
   localparam logic [31:0] P2C_RESET_WORD    = 32'h0000_0000;

   // ****************************************************************
   // pad carrier
   // ****************************************************************
   typedef struct packed {
      logic [P2C_WIDTH-1:0] level;
      logic [P2C_WIDTH-1:0] drive_en;
      logic [P2C_WIDTH-1:0] pullup_on;
   } p2c_pad_t;

endpackage

/* design/p2c_port.sv */
// module: port 2 pad drive, pull-up and pin readback with a classic wishbone slave
// Notes on behaviour
// - bits 0-2,5-7 drive-type bit 0 push-pull, 1 open-drain; bits 3,4 read zero.
// - pull-up connects only if enabled and pin is input or open-drain output.
// - pin read gives 0 for an output bit 0-2,5-7 with push-pull drive.
// - bits 0-2,5-7 read pin level when input or open-drain output.
// - pin read bits 3 and 4 always return the pin level.
// - direction bit 0 input, 1 output; reset makes all pins inputs.
// - output drives low on latch 0; latch 1 drives high or releases if open-drain.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
module p2c_port
   import p2c_pkg::*;
   #(
   parameter int WIDTH = P2C_WIDTH
   ) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     cyc_i,
   input  wire logic                     stb_i,
   input  wire logic                     we_i,
   input  wire logic [P2C_ADR_WIDTH-1:0] adr_i,
   input  wire logic [3:0]               sel_i,
   input  wire logic [31:0]              dat_i,
   output logic      [31:0]              dat_o,
   output logic                          ack_o,
   input  wire logic [WIDTH-1:0]         pad_in_i,
   output p2c_pad_t                      pad_o
   );

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [WIDTH-1:0] direction_reg;
   logic [WIDTH-1:0] latch_reg;
   logic [WIDTH-1:0] drive_type_reg;
   logic [WIDTH-1:0] pullup_reg;

   logic [WIDTH-1:0] sync1_reg;
   logic [WIDTH-1:0] sync2_reg;
   logic [WIDTH-1:0] sync3_reg;
   logic [WIDTH-1:0] pin_reg;
   logic [WIDTH-1:0] pin_next;

   logic [WIDTH-1:0] drive_en_bits;
   logic [WIDTH-1:0] pullup_bits;
   logic [WIDTH-1:0] readback;
   logic [31:0]      rdata_next;

   logic [WIDTH-1:0] wdata;
   logic [WIDTH-1:0] drive_type_wdata;
   logic [WIDTH-1:0] pullup_wdata;

   logic             ack_reg;
   logic [31:0]      dat_reg;
   logic             req;
   logic             wr;
   logic [13:0]      idx;
   logic             hit_output_latch;
   logic             hit_direction;
   logic             hit_pullup_enable;
   logic             hit_drive_type;

   // ****************************************************************
   // request decode
   // ****************************************************************
   // ack_reg blocks a second take of a request still held in the ack cycle
   assign req = cyc_i & stb_i & ~ack_reg;
   assign wr  = req & we_i & sel_i[0];
   assign idx = adr_i[P2C_ADR_WIDTH-1:P2C_ADR_LSB];

   assign hit_output_latch  = (idx == P2C_IDX_OUTPUT_LATCH);
   assign hit_direction     = (idx == P2C_IDX_DIRECTION);
   assign hit_pullup_enable = (idx == P2C_IDX_PULLUP_ENABLE);
   assign hit_drive_type    = (idx == P2C_IDX_DRIVE_TYPE);

   // ****************************************************************
   // register write data
   // ****************************************************************
   // read-only positions are masked off before they reach the registers
   assign wdata            = dat_i[WIDTH-1:0];
   assign drive_type_wdata = wdata & P2C_CTRL_MASK[WIDTH-1:0];
   assign pullup_wdata     = wdata & P2C_CTRL_MASK[WIDTH-1:0];

   // ****************************************************************
   // pin input synchroniser and agreement filter
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg <= P2C_RESET_BYTE;
         sync2_reg <= P2C_RESET_BYTE;
         sync3_reg <= P2C_RESET_BYTE;
      end else begin
         sync1_reg <= pad_in_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // ****************************************************************
   // agreement filter, per bit
   // ****************************************************************
   for (genvar b = 0; b < WIDTH; b++) begin : g_filter
      logic agree;

      // a one-cycle glitch never sees stages two and three agree
      assign agree       = ~(sync2_reg[b] ^ sync3_reg[b]);
      assign pin_next[b] = agree ? sync2_reg[b] : pin_reg[b];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_reg <= P2C_RESET_BYTE;
      end else begin
         pin_reg <= pin_next;
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         direction_reg <= P2C_RESET_BYTE;
      end else if (wr && hit_direction) begin
         direction_reg <= dat_i[WIDTH-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_reg <= P2C_RESET_BYTE;
      end else if (wr && hit_output_latch) begin
         latch_reg <= wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_type_reg <= P2C_RESET_BYTE;
      end else if (wr && hit_drive_type) begin
         drive_type_reg <= drive_type_wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pullup_reg <= P2C_RESET_BYTE;
      end else if (wr && hit_pullup_enable) begin
         pullup_reg <= pullup_wdata;
      end
   end

   // ****************************************************************
   // per-bit pad drive, pull-up and readback
   // ****************************************************************
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      logic is_output;
      logic is_open_drain;
      logic always_pin;

      assign is_output     = direction_reg[b];
      assign is_open_drain = drive_type_reg[b];
      assign always_pin    = P2C_ALWAYS_PIN[b];

      // open-drain with latch high releases the pin
      assign drive_en_bits[b] = is_output & (~latch_reg[b] | ~is_open_drain);
      assign pullup_bits[b]   = pullup_reg[b] & (~is_output | is_open_drain);
      // push-pull outputs read zero, except the two always-pin bits
      assign readback[b]      = pin_reg[b] & (always_pin | ~is_output | is_open_drain);
   end

   // ****************************************************************
   // pad carrier
   // ****************************************************************
   assign pad_o = '{
      level:     latch_reg,
      drive_en:  drive_en_bits,
      pullup_on: pullup_bits
   };

   // ****************************************************************
   // read data select
   // ****************************************************************
   always_comb begin
      rdata_next = P2C_RESET_WORD;
      unique case (idx)
         P2C_IDX_PIN_LEVELS:    rdata_next[WIDTH-1:0] = readback;
         P2C_IDX_OUTPUT_LATCH:  rdata_next[WIDTH-1:0] = latch_reg;
         P2C_IDX_DIRECTION:     rdata_next[WIDTH-1:0] = direction_reg;
         P2C_IDX_PULLUP_ENABLE: rdata_next[WIDTH-1:0] = pullup_reg;
         P2C_IDX_DRIVE_TYPE:    rdata_next[WIDTH-1:0] = drive_type_reg;
         default:               rdata_next = P2C_RESET_WORD;
      endcase
   end

   // ****************************************************************
   // wishbone answer
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end

   // ****************************************************************
   // read data, held until the next taken request
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= P2C_RESET_WORD;
      end else if (req) begin
         dat_reg <= rdata_next;
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;

endmodule

/* sim/p2c_pins.sv */
// model of the circuitry on the port 2 pins
`timescale 1ns/10ps
module p2c_pins
   import p2c_pkg::*;
   (
   input  wire p2c_pad_t   pad_i,
   input  wire logic [7:0] ext_i,
   output logic      [7:0] pin_o
   );
   // driven bits follow the latch; released bits go to the pull-up or the outside driver
   assign pin_o = (pad_i.drive_en & pad_i.level) | (~pad_i.drive_en & (pad_i.pullup_on | ext_i));
endmodule

/* sim/p2c_port_properties.sv */
// checker: bus and pad relations of the port 2 block
`timescale 1ns/10ps
module p2c_port_properties
   import p2c_pkg::*;
   #(parameter int WIDTH = P2C_WIDTH) (
   input wire logic                     clk_i,
   input wire logic                     rst_i,
   input wire logic                     cyc_i,
   input wire logic                     stb_i,
   input wire logic                     we_i,
   input wire logic [P2C_ADR_WIDTH-1:0] adr_i,
   input wire logic [3:0]               sel_i,
   input wire logic [31:0]              dat_i,
   input wire logic [31:0]              dat_o,
   input wire logic                     ack_o,
   input wire logic [WIDTH-1:0]         pad_in_i,
   input wire p2c_pad_t                 pad_o
   );
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_follows_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   reset_pads_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> pad_o == '0)
      else $error("pads not idle after reset");
   upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
   unmapped_zero_a: assert property (ack_o && !we_i && adr_i == 16'h0100 |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   pads_quiet_a: assert property (!$stable(pad_o) |-> $past(cyc_i && stb_i && we_i))
      else $error("pads changed without write");
   no_pull_mid_a: assert property (pad_o.pullup_on[4:3] == 2'b00)
      else $error("pull-up on bit 3 or 4");
   pull_drive_a: assert property ((pad_o.pullup_on & pad_o.drive_en & pad_o.level) == 8'h00)
      else $error("pull-up on a driven high pin");
endmodule
bind p2c_port p2c_port_properties #(.WIDTH(WIDTH)) p2c_port_properties_inst (
   .clk_i    (clk_i),
   .rst_i    (rst_i),
   .cyc_i    (cyc_i),
   .stb_i    (stb_i),
   .we_i     (we_i),
   .adr_i    (adr_i),
   .sel_i    (sel_i),
   .dat_i    (dat_i),
   .dat_o    (dat_o),
   .ack_o    (ack_o),
   .pad_in_i (pad_in_i),
   .pad_o    (pad_o)
);

/* sim/testbench.sv */
// testbench: register accesses and pin readback of the port 2 block
`timescale 1ns/10ps
module testbench;
   import p2c_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
   logic [15:0] adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o;
   logic [7:0]  pad_in_i, ext, q;
   p2c_pad_t    pad_o;
   int          num_errors = 0;
   int          total_checks = 0;
   localparam logic [15:0] A_P = {P2C_IDX_PIN_LEVELS, 2'b00};
   localparam logic [15:0] A_L = {P2C_IDX_OUTPUT_LATCH, 2'b00};
   localparam logic [15:0] A_D = {P2C_IDX_DIRECTION, 2'b00};
   localparam logic [15:0] A_U = {P2C_IDX_PULLUP_ENABLE, 2'b00};
   localparam logic [15:0] A_T = {P2C_IDX_DRIVE_TYPE, 2'b00};
   p2c_port p2c_port_inst (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .cyc_i    (cyc_i),
      .stb_i    (stb_i),
      .we_i     (we_i),
      .adr_i    (adr_i),
      .sel_i    (sel_i),
      .dat_i    (dat_i),
      .dat_o    (dat_o),
      .ack_o    (ack_o),
      .pad_in_i (pad_in_i),
      .pad_o    (pad_o)
   );
   p2c_pins p2c_pins_inst (.pad_i(pad_o), .ext_i(ext), .pin_o(pad_in_i));
   task bus(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [7:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, 24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o[7:0];
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      repeat (6) @(posedge clk_i);
      bus(1'b0, a, 4'hF, 8'h00);
      chk(q, e);
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      bus(1'b1, a, 4'h1, d);
   endtask
   task close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      num_errors++;
      close_out;
   end
   initial begin
      {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, ext} = {4'h8, 52'h0, 8'h10};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(A_T, 8'h00);
      rd(A_U, 8'h00);
      rd(A_D, 8'h00);
      chk(pad_o.drive_en | pad_o.pullup_on, 8'h00);
      wr(A_T, 8'hFF);
      rd(A_T, P2C_CTRL_MASK);
      wr(A_U, 8'hFF);
      rd(A_U, P2C_CTRL_MASK);
      chk(pad_o.pullup_on, 8'hE7);
      rd(A_P, 8'hF7);
      wr(A_L, 8'h0F);
      wr(A_D, 8'hFF);
      rd(A_D, 8'hFF);
      chk(pad_o.level, 8'h0F);
      chk(pad_o.drive_en, 8'hF8);
      chk(pad_o.pullup_on, 8'hE7);
      rd(A_P, 8'h0F);
      wr(A_T, 8'h00);
      chk(pad_o.drive_en, 8'hFF);
      chk(pad_o.pullup_on, 8'h00);
      rd(A_P, 8'h08);
      bus(1'b1, A_L, 4'h0, 8'hFF);
      rd(A_L, 8'h0F);
      wr(A_P, 8'hFF);
      rd(A_P, 8'h08);
      rd(16'h0100, 8'h00);
      close_out;
   end
endmodule
